// ===== verilog/rtsr_pkg.sv
// constants for the radio test and status register bank
// assumes an 8-bit serial configuration port and a 5-bit radio state code
package rtsr_pkg;

    // ----------------------------------------
    // header byte fields
    // ----------------------------------------
    localparam int HDR_RW_BIT = 7;
    localparam int HDR_BURST_BIT = 6;

    // ----------------------------------------
    // test registers, lost in sleep
    // ----------------------------------------
    localparam logic [5:0] ADDR_SYNTH_TEST = 6'h29;
    localparam logic [5:0] ADDR_PROD_TEST = 6'h2a;
    localparam logic [5:0] ADDR_GAIN_CTRL_TEST = 6'h2b;
    localparam logic [5:0] ADDR_TEST_SETTING_C = 6'h2c;
    localparam logic [5:0] ADDR_TEST_SETTING_B = 6'h2d;
    localparam logic [5:0] ADDR_TEST_SETTING_A = 6'h2e;
    localparam int NUM_TEST_REGS = 6;

    localparam logic [7:0] RST_SYNTH_TEST = 8'h59;
    localparam logic [7:0] RST_PROD_TEST = 8'h7f;
    localparam logic [7:0] RST_GAIN_CTRL_TEST = 8'h3f;
    localparam logic [7:0] RST_TEST_SETTING_C = 8'h88;
    localparam logic [7:0] RST_TEST_SETTING_B = 8'h31;
    localparam logic [7:0] RST_TEST_SETTING_A = 8'h0b;

    // production-test value that exposes the temperature sensor in idle
    localparam logic [7:0] PROD_TEST_TEMP_SENSE = 8'hbf;

    // ----------------------------------------
    // status registers (read with burst bit set)
    // ----------------------------------------
    localparam logic [5:0] ADDR_STATUS_FIRST = 6'h30;
    localparam logic [5:0] ADDR_PART_IDENTIFIER = 6'h30;
    localparam logic [5:0] ADDR_SILICON_REVISION = 6'h31;
    localparam logic [5:0] ADDR_CARRIER_OFFSET = 6'h32;
    localparam logic [5:0] ADDR_LINK_QUALITY_CRC = 6'h33;
    localparam logic [5:0] ADDR_SIGNAL_STRENGTH = 6'h34;
    localparam logic [5:0] ADDR_RADIO_FSM_STATE = 6'h35;

    localparam int CRC_OK_BIT = 7;
    localparam int FSM_STATE_WIDTH = 5;

    // ----------------------------------------
    // radio state codes of interest
    // ----------------------------------------
    localparam logic [4:0] STATE_SLEEP = 5'h00;
    localparam logic [4:0] STATE_IDLE = 5'h01;
    localparam logic [4:0] STATE_OSCILLATOR_OFF = 5'h02;
    localparam logic [4:0] STATE_LAST_CODE = 5'h16;

    // byte returned while the header is shifted in
    localparam logic [7:0] HEADER_REPLY = 8'h00;

    typedef enum logic {PH_HEADER, PH_DATA} rtsr_phase_t;

endpackage : rtsr_pkg

// ===== verilog/rtsr_spi_slave.sv
// serial configuration port slave: synchronises pins, frames bytes
// assumes sclk idles low, data sampled on rising edge, sclk <= mclk/8
`timescale 1ns/100ps
module rtsr_spi_slave
    import rtsr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic csn_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic [7:0] tx_byte_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic select_start_out,
    output logic byte_done_out,
    output logic [7:0] rx_byte_out
);
    import rtsr_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic csn_s1_reg, csn_s2_reg, csn_d_reg;
    logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
    logic mosi_s1_reg, mosi_s2_reg;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            csn_s1_reg <= 1'b1;
            csn_s2_reg <= 1'b1;
            csn_d_reg <= 1'b1;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
        end
        else
        begin
            csn_s1_reg <= csn_n_in;
            csn_s2_reg <= csn_s1_reg;
            csn_d_reg <= csn_s2_reg;
            sclk_s1_reg <= sclk_in;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_d_reg <= sclk_s2_reg;
            mosi_s1_reg <= mosi_in;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    logic sel_start, sclk_rise, sclk_fall;
    assign sel_start = csn_d_reg & ~csn_s2_reg;
    assign sclk_rise = sclk_s2_reg & ~sclk_d_reg & ~csn_s2_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_d_reg & ~csn_s2_reg;

    // ----------------------------------------
    // byte framing
    // ----------------------------------------
    logic [6:0] shift_in_reg, shift_in_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] rx_byte_reg, rx_byte_next;
    logic done_reg, done_next;
    logic [7:0] shift_out_reg, shift_out_next;

    always_comb
    begin
        shift_in_next = shift_in_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_byte_next = rx_byte_reg;
        done_next = 1'b0;
        shift_out_next = shift_out_reg;
        if (sel_start)
        begin
            bit_cnt_next = 3'h0;
            shift_out_next = HEADER_REPLY;
        end
        else if (sclk_rise)
        begin
            shift_in_next = {shift_in_reg[5:0], mosi_s2_reg};
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
                done_next = 1'b1;
                rx_byte_next = {shift_in_reg, mosi_s2_reg};
            end
        end
        else if (sclk_fall)
        begin
            // count wrapped: a whole byte went by, start the next reply
            if (bit_cnt_reg == 3'h0)
                shift_out_next = tx_byte_in;
            else
                shift_out_next = {shift_out_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            shift_in_reg <= 7'h00;
            bit_cnt_reg <= 3'h0;
            rx_byte_reg <= 8'h00;
            done_reg <= 1'b0;
            shift_out_reg <= 8'h00;
        end
        else
        begin
            shift_in_reg <= shift_in_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_byte_reg <= rx_byte_next;
            done_reg <= done_next;
            shift_out_reg <= shift_out_next;
        end
    end

    assign miso_out = shift_out_reg[7];
    assign miso_oe_out = ~csn_s2_reg;
    assign select_start_out = sel_start;
    assign byte_done_out = done_reg;
    assign rx_byte_out = rx_byte_reg;

endmodule : rtsr_spi_slave

// ===== verilog/rtsr_test_regs.sv
// the six test and configuration registers that do not survive sleep
// assumes the write strobe already excludes status accesses
`timescale 1ns/100ps
module rtsr_test_regs
    import rtsr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic sleep_in,
    input wire logic wr_en_in,
    input wire logic [5:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] synth_test_reg_out,
    output logic [7:0] production_test_reg_out,
    output logic [7:0] gain_ctrl_test_reg_out,
    output logic [7:0] test_setting_c_out,
    output logic [7:0] test_setting_b_out,
    output logic [7:0] test_setting_a_out
);
    import rtsr_pkg::*;

    localparam logic [7:0] RST_VAL [NUM_TEST_REGS] = '{
        RST_SYNTH_TEST, RST_PROD_TEST, RST_GAIN_CTRL_TEST,
        RST_TEST_SETTING_C, RST_TEST_SETTING_B, RST_TEST_SETTING_A};

    logic [7:0] regs_reg [NUM_TEST_REGS];
    logic [7:0] regs_next [NUM_TEST_REGS];
    logic [5:0] idx;

    assign idx = wr_addr_in - ADDR_SYNTH_TEST;

    always_comb
    begin
        for (int i = 0; i < NUM_TEST_REGS; i++)
        begin
            regs_next[i] = regs_reg[i];
            // contents are gone once the radio sleeps
            if (sleep_in)
                regs_next[i] = RST_VAL[i];
            else if (wr_en_in && idx == 6'(i))
                regs_next[i] = wr_data_in;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < NUM_TEST_REGS; i++)
        begin
            if (!rst_n_in)
                regs_reg[i] <= RST_VAL[i];
            else
                regs_reg[i] <= regs_next[i];
        end
    end

    assign synth_test_reg_out = regs_reg[0];
    assign production_test_reg_out = regs_reg[1];
    assign gain_ctrl_test_reg_out = regs_reg[2];
    assign test_setting_c_out = regs_reg[3];
    assign test_setting_b_out = regs_reg[4];
    assign test_setting_a_out = regs_reg[5];

    a_sleep_wipes_regs : assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        sleep_in |=> (regs_reg[1] == RST_PROD_TEST)
            && (regs_reg[3] == RST_TEST_SETTING_C)
            && (regs_reg[5] == RST_TEST_SETTING_A))
        else $error("test registers kept a value through sleep");

endmodule : rtsr_test_regs

// ===== verilog/rtsr_top.sv
// test and status register bank of the radio, reached over the serial port
// assumes modem, packet engine and radio state machine on the same clock
//
// How it works
// - the six test registers return to their defaults whenever the radio sleeps.
// - production-test value 0xbf turns the temperature sensor on while idle.
// - the general test registers reset to 0x88, 0x31 and 0x0b and take host values.
// - part number and silicon revision read back from status addresses.
// - the carrier offset estimate reads as an 8-bit two's complement value.
// - with on-off keying the carrier offset estimate reads zero.
// - bit 7 of link quality is the last crc match, cleared on receive entry.
// - bits 6:0 of link quality carry the demodulation-ease estimate.
// - received signal strength reads as an 8-bit status register.
// - the radio state reads in bits 4:0 with bits 7:5 zero.
// - state codes 0 to 12 cover sleep, idle, calibration and settling.
// - state codes 13 to 22 cover receive and transmit phases.
// - a port access while asleep or with oscillator off wakes the radio.
`timescale 1ns/100ps
module rtsr_top
    import rtsr_pkg::*;
#(
    parameter logic [7:0] PART_ID_VALUE = 8'h5a,   // arbitrary
    parameter logic [7:0] REVISION_VALUE = 8'h01   // arbitrary
)
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic csn_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire logic [4:0] radio_fsm_state_in,
    input wire logic [7:0] offset_estimate_value_in,
    input wire logic ook_mode_in,
    input wire logic crc_check_done_in,
    input wire logic crc_match_in,
    input wire logic rx_start_in,
    input wire logic [6:0] link_quality_value_in,
    input wire logic [7:0] signal_strength_in,
    output logic wake_request_out,
    output logic temp_sensor_enable_out,
    output logic [7:0] synth_test_reg_out,
    output logic [7:0] production_test_reg_out,
    output logic [7:0] gain_ctrl_test_reg_out,
    output logic [7:0] test_setting_c_out,
    output logic [7:0] test_setting_b_out,
    output logic [7:0] test_setting_a_out
);
    import rtsr_pkg::*;

    // ----------------------------------------
    // serial port and test registers
    // ----------------------------------------
    logic sel_start, byte_done;
    logic [7:0] rx_byte;
    logic [7:0] rd_byte_reg, rd_byte_next;
    logic wr_en;
    logic [5:0] wr_addr;
    logic sleeping;

    rtsr_spi_slave u_spi (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .csn_n_in(csn_n_in),
        .sclk_in(sclk_in),
        .mosi_in(mosi_in),
        .tx_byte_in(rd_byte_reg),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .select_start_out(sel_start),
        .byte_done_out(byte_done),
        .rx_byte_out(rx_byte)
    );

    assign sleeping = (radio_fsm_state_in == STATE_SLEEP);

    rtsr_test_regs u_regs (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sleep_in(sleeping),
        .wr_en_in(wr_en),
        .wr_addr_in(wr_addr),
        .wr_data_in(rx_byte),
        .synth_test_reg_out(synth_test_reg_out),
        .production_test_reg_out(production_test_reg_out),
        .gain_ctrl_test_reg_out(gain_ctrl_test_reg_out),
        .test_setting_c_out(test_setting_c_out),
        .test_setting_b_out(test_setting_b_out),
        .test_setting_a_out(test_setting_a_out)
    );

    // ----------------------------------------
    // crc match flag
    // ----------------------------------------
    logic crc_ok_reg, crc_ok_next, crc_set;
    assign crc_set = crc_check_done_in & crc_match_in;

    always_comb
    begin
        crc_ok_next = crc_ok_reg;
        // a match in the same cycle as a receive restart is kept
        if (crc_set)
            crc_ok_next = 1'b1;
        else if (rx_start_in)
            crc_ok_next = 1'b0;
    end

    // ----------------------------------------
    // read data mux
    // ----------------------------------------
    function automatic logic [7:0] read_mux(input logic [5:0] addr,
                                            input logic status);
        logic [7:0] val;
        val = 8'h00;
        if (status)
        begin
            unique case (addr)
                ADDR_PART_IDENTIFIER: val = PART_ID_VALUE;
                ADDR_SILICON_REVISION: val = REVISION_VALUE;
                ADDR_CARRIER_OFFSET:
                    val = ook_mode_in ? 8'h00 : offset_estimate_value_in;
                ADDR_LINK_QUALITY_CRC:
                    val = {crc_ok_reg, link_quality_value_in};
                ADDR_SIGNAL_STRENGTH: val = signal_strength_in;
                ADDR_RADIO_FSM_STATE:
                    val = {3'h0, radio_fsm_state_in};
                default: val = 8'h00;
            endcase
        end
        else
        begin
            unique case (addr)
                ADDR_SYNTH_TEST: val = synth_test_reg_out;
                ADDR_PROD_TEST: val = production_test_reg_out;
                ADDR_GAIN_CTRL_TEST: val = gain_ctrl_test_reg_out;
                ADDR_TEST_SETTING_C: val = test_setting_c_out;
                ADDR_TEST_SETTING_B: val = test_setting_b_out;
                ADDR_TEST_SETTING_A: val = test_setting_a_out;
                default: val = 8'h00;
            endcase
        end
        return val;
    endfunction : read_mux

    // ----------------------------------------
    // access sequencing
    // ----------------------------------------
    rtsr_phase_t phase_reg, phase_next;
    logic [5:0] addr_reg, addr_next;
    logic write_reg, write_next;
    logic burst_reg, burst_next;
    logic status_reg, status_next;
    logic hdr_status;
    logic wake_reg, wake_next;
    logic temp_reg, temp_next;

    // status space needs both read and burst bits
    assign hdr_status = rx_byte[HDR_RW_BIT] & rx_byte[HDR_BURST_BIT]
        & (rx_byte[5:0] >= ADDR_STATUS_FIRST);

    always_comb
    begin
        phase_next = phase_reg;
        addr_next = addr_reg;
        write_next = write_reg;
        burst_next = burst_reg;
        status_next = status_reg;
        rd_byte_next = rd_byte_reg;
        wr_en = 1'b0;
        wr_addr = addr_reg;
        if (sel_start)
            phase_next = PH_HEADER;
        else if (byte_done)
        begin
            unique case (phase_reg)
                PH_HEADER:
                begin
                    addr_next = rx_byte[5:0];
                    write_next = ~rx_byte[HDR_RW_BIT];
                    burst_next = rx_byte[HDR_BURST_BIT] & ~hdr_status;
                    status_next = hdr_status;
                    rd_byte_next = read_mux(rx_byte[5:0], hdr_status);
                    phase_next = PH_DATA;
                end
                PH_DATA:
                begin
                    // status and command space is never written here
                    wr_en = write_reg & ~status_reg
                        & (addr_reg < ADDR_STATUS_FIRST);
                    if (burst_reg)
                    begin
                        addr_next = addr_reg + 6'h01;
                        rd_byte_next = read_mux(addr_next, 1'b0);
                    end
                    else
                        phase_next = PH_HEADER;
                end
            endcase
        end
    end

    always_comb
    begin
        // any access while the oscillator is down restarts it
        wake_next = sel_start && (sleeping
            || radio_fsm_state_in == STATE_OSCILLATOR_OFF);
        temp_next = (production_test_reg_out == PROD_TEST_TEMP_SENSE)
            && (radio_fsm_state_in == STATE_IDLE);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            phase_reg <= PH_HEADER;
            addr_reg <= 6'h00;
            write_reg <= 1'b0;
            burst_reg <= 1'b0;
            status_reg <= 1'b0;
            rd_byte_reg <= 8'h00;
            crc_ok_reg <= 1'b0;
            wake_reg <= 1'b0;
            temp_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            addr_reg <= addr_next;
            write_reg <= write_next;
            burst_reg <= burst_next;
            status_reg <= status_next;
            rd_byte_reg <= rd_byte_next;
            crc_ok_reg <= crc_ok_next;
            wake_reg <= wake_next;
            temp_reg <= temp_next;
        end
    end

    assign wake_request_out = wake_reg;
    assign temp_sensor_enable_out = temp_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_status_hdr(logic [5:0] a);
        byte_done && phase_reg == PH_HEADER && hdr_status
            && rx_byte[5:0] == a;
    endsequence

    a_temp_sense_on : assert property (
        (production_test_reg_out == PROD_TEST_TEMP_SENSE
            && radio_fsm_state_in == STATE_IDLE) |=> temp_sensor_enable_out)
        else $error("temperature sensor not enabled");
    a_temp_sense_off : assert property (
        radio_fsm_state_in != STATE_IDLE |=> !temp_sensor_enable_out)
        else $error("temperature sensor enabled outside idle");
    a_part_id_read : assert property (
        s_status_hdr(ADDR_PART_IDENTIFIER) |=> rd_byte_reg == PART_ID_VALUE)
        else $error("wrong part identifier");
    a_ook_offset_zero : assert property (
        s_status_hdr(ADDR_CARRIER_OFFSET) and ook_mode_in
            |=> rd_byte_reg == 8'h00)
        else $error("offset estimate not zero under on-off keying");
    a_crc_set_wins : assert property (
        crc_set |=> crc_ok_reg)
        else $error("crc match lost");
    a_crc_rx_clear : assert property (
        rx_start_in && !crc_set |=> !crc_ok_reg ##1
            (crc_ok_reg == $past(crc_set)))
        else $error("crc flag not cleared on receive entry");
    a_state_reserved_zero : assert property (
        s_status_hdr(ADDR_RADIO_FSM_STATE)
            |=> rd_byte_reg[7:5] == 3'h0
            && rd_byte_reg[4:0] == $past(radio_fsm_state_in))
        else $error("radio state read wrong");
    a_wake_on_access : assert property (
        sel_start && sleeping |=> wake_request_out ##1 !wake_request_out)
        else $error("no wake request on access");
    a_status_no_write : assert property (
        byte_done && phase_reg == PH_DATA && status_reg |-> !wr_en)
        else $error("status access produced a write");

endmodule : rtsr_top

// ===== tb/rtsr_host_model.sv
// host controller model for the serial configuration port
// assumes mclk_in at 100 MHz; sclk runs at mclk/10, idle low
`timescale 1ns/100ps
module rtsr_host_model
(
    input wire logic mclk_in,
    input wire logic miso_in,
    output logic csn_n_out,
    output logic sclk_out,
    output logic mosi_out
);
    initial
    begin
        csn_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end

    // ----------------------------------------
    // one frame: header then one data byte
    // ----------------------------------------
    // sclk stands still outside frames; mosi flips once released
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge mclk_in);
        csn_n_out <= 1'b0;
        repeat (4) @(negedge mclk_in);
        for (int i = 15; i >= 0; i--)
        begin
            mosi_out <= tx[i];
            repeat (5) @(negedge mclk_in);
            sclk_out <= 1'b1;
            if (i < 8)
            begin
                rd[i] = miso_in;
            end
            repeat (5) @(negedge mclk_in);
            sclk_out <= 1'b0;
        end
        repeat (5) @(negedge mclk_in);
        csn_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        repeat (6) @(negedge mclk_in);
    endtask : xfer
endmodule : rtsr_host_model

// ===== tb/rtsr_bench.sv
// self-checking bench for the test and status register bank
// assumes the host model as the only master of the serial port
`timescale 1ns/100ps
module rtsr_bench;
    import rtsr_pkg::*;
    localparam logic [7:0] PART_ID = 8'ha6; // arbitrary
    localparam logic [7:0] REV_ID = 8'h1c; // arbitrary
    typedef struct packed {logic [15:0] tx; logic [7:0] exp;} rtsr_row_t;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic csn_n, sclk, mosi, miso, miso_oe, wake, temp_en;
    logic [4:0] state = 5'h0d;
    logic [7:0] offset = 8'hf3;
    logic ook = 1'b0;
    logic crc_done = 1'b0;
    logic crc_match = 1'b0;
    logic rx_start = 1'b0;
    logic [6:0] lq = 7'h2b;
    logic [7:0] ss = 8'h9c;
    logic [7:0] treg [6];
    logic [7:0] rd;
    logic wake_seen = 1'b0;
    logic oe_seen = 1'b0;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    rtsr_row_t rows [11] = '{
        '{16'hf000, PART_ID}, '{16'hf100, REV_ID}, '{16'hf200, 8'hf3},
        '{16'hf400, 8'h9c}, '{16'hf500, 8'h0d},
        '{16'ha900, RST_SYNTH_TEST}, '{16'haa00, RST_PROD_TEST},
        '{16'hab00, RST_GAIN_CTRL_TEST}, '{16'hac00, RST_TEST_SETTING_C},
        '{16'had00, RST_TEST_SETTING_B}, '{16'hae00, RST_TEST_SETTING_A}};

    rtsr_top #(.PART_ID_VALUE(PART_ID), .REVISION_VALUE(REV_ID)) dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .csn_n_in(csn_n),
        .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .radio_fsm_state_in(state),
        .offset_estimate_value_in(offset), .ook_mode_in(ook),
        .crc_check_done_in(crc_done), .crc_match_in(crc_match),
        .rx_start_in(rx_start), .link_quality_value_in(lq),
        .signal_strength_in(ss), .wake_request_out(wake),
        .temp_sensor_enable_out(temp_en), .synth_test_reg_out(treg[0]),
        .production_test_reg_out(treg[1]), .gain_ctrl_test_reg_out(treg[2]),
        .test_setting_c_out(treg[3]), .test_setting_b_out(treg[4]),
        .test_setting_a_out(treg[5]));

    rtsr_host_model host (.mclk_in(mclk_in), .miso_in(miso),
        .csn_n_out(csn_n), .sclk_out(sclk), .mosi_out(mosi));

    always #5 mclk_in = ~mclk_in;

    // ----------------------------------------
    // pulse catcher and hang guard
    // ----------------------------------------
    always @(posedge mclk_in)
    begin
        cycles++;
        if (wake === 1'b1)
        begin
            wake_seen <= 1'b1;
        end
        if (miso_oe === 1'b1)
        begin
            oe_seen <= 1'b1;
        end
        if (cycles == 30000)
        begin
            errors++;
            final_report();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check

    task automatic rd_chk(input logic [15:0] tx, input logic [7:0] exp);
        host.xfer(tx, rd);
        check(rd, exp);
    endtask : rd_chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(negedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(negedge mclk_in);
        check({7'h00, miso_oe}, 8'h00);
        foreach (rows[i])
        begin
            rd_chk(rows[i].tx, rows[i].exp);
        end
        check({7'h00, oe_seen}, 8'h01);
        $display("table done");
        // host never writes 0x29 or 0x2b
        state <= STATE_IDLE;
        host.xfer({2'b00, ADDR_PROD_TEST, PROD_TEST_TEMP_SENSE}, rd);
        check({7'h00, temp_en}, 8'h01);
        host.xfer({2'b00, ADDR_PROD_TEST, RST_PROD_TEST}, rd);
        check({7'h00, temp_en}, 8'h00);
        state <= 5'h0d;
        $display("temperature sensor done");
        host.xfer({2'b00, ADDR_TEST_SETTING_A, 8'h5c}, rd);
        rd_chk(16'hae00, 8'h5c);
        host.xfer({2'b01, ADDR_SIGNAL_STRENGTH, 8'h00}, rd);
        rd_chk(16'hf400, 8'h9c);
        ook <= 1'b1;
        rd_chk(16'hf200, 8'h00);
        ook <= 1'b0;
        $display("write and keying done");
        crc_done <= 1'b1;
        crc_match <= 1'b1;
        @(negedge mclk_in);
        crc_done <= 1'b0;
        crc_match <= 1'b0;
        rd_chk(16'hf300, 8'hab);
        rx_start <= 1'b1;
        @(negedge mclk_in);
        rx_start <= 1'b0;
        rd_chk(16'hf300, 8'h2b);
        $display("link quality done");
        // every state code; only sleep and oscillator-off ask for wake
        for (int s = 0; s <= 22; s++)
        begin
            state <= s[4:0];
            wake_seen <= 1'b0;
            rd_chk(16'hf500, {3'b000, s[4:0]});
            check({7'h00, wake_seen}, {7'h00, s == 0 || s == 2});
        end
        check(treg[5], RST_TEST_SETTING_A);
        check(treg[0], RST_SYNTH_TEST);
        check(treg[2], RST_GAIN_CTRL_TEST);
        $display("state codes and sleep done");
        // mid-run reset: a written value goes back to its default
        host.xfer({2'b00, ADDR_TEST_SETTING_B, 8'h77}, rd);
        check(treg[4], 8'h77);
        rst_n_in <= 1'b0;
        repeat (8) @(negedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(negedge mclk_in);
        check({7'h00, miso_oe}, 8'h00);
        check({7'h00, wake}, 8'h00);
        check(treg[4], RST_TEST_SETTING_B);
        rd_chk(16'had00, RST_TEST_SETTING_B);
        $display("mid-run reset done");
        final_report();
    end
endmodule : rtsr_bench
